// [logic/host_port_params.svh]
// Constants for the parallel host register port.
// Summary of operation
// RULE1: In direct-address modes addr_select low moves data, high moves the pointer.
// RULE2: Host writes the pointer with addr_select high, then moves data low.
// RULE3: The pointer is kept, so repeated data accesses reach the same register.
// RULE4: In latched-address modes the host holds addr_select low; it is ignored.
// RULE5: In latched-address modes a high latch strobe loads the pointer from the bus.
// RULE6: Upper-range reads are two-step; the first read returns junk to discard.
// RULE7: After the junk read the indirect data register returns the target value.
// RULE8: All other registers return their true value on one read.
// RULE9: An address read with addr_select high returns the current pointer.
// RULE10: Read is chip select and read strobe low with write indication inactive.
// RULE11: The port drives the bus only during the read strobe, then releases it; the code drives and releases it three clocks late, behind the synchroniser.
// RULE12: Write data or pointer is taken at the trailing edge of the strobe.
// RULE13: Host spaces data accesses by 30 ns low range, 3.5 clocks high range.
// RULE14: Wait goes low only on too-close data phases, for at most the cycle time.
// RULE15: A host meeting the spacing may leave the wait output unused.
// RULE16: Interrupt handlers should save and restore the pointer around accesses.
// RULE17: First latch strobe rise after reset selects latched-address mode forever.
// RULE18: Latch strobe edges during reset are ignored.
// RULE19: Host strobes pass a two-stage synchroniser before any state changes.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
// ==========================================================================
// Register map points
`define INDIRECT_DATA_ADDR 8'h88
`define TARGET_BASE_ADDR   8'hc0
`define UPPER_HALF_BIT     7
`define JUNK_READ_VALUE    8'h00
`define POINTER_RESET      8'h00
// ==========================================================================
// Timing
`define T_SYS_NS           100
`define T_CYC_LO_NS        30
`define T_CYC_HI_TENTHS    35
`define CYC_LO_CYCLES ((`T_CYC_LO_NS + `T_SYS_NS - 1) / `T_SYS_NS)
`define CYC_HI_CYCLES ((`T_CYC_HI_TENTHS + 9) / 10)
`define GAP_MAX            3'h7
`endif

// [logic/host_port_pkg.sv]
// Types shared by the parallel host register port.
package host_port_pkg;
  // ========================================================================
  // Pin group and access states
  typedef struct packed {
    logic       cs_n;
    logic       read_strobe_pin_n;
    logic       write_strobe_pin_n;
    logic       ale;
    logic       addr_select;
    logic [7:0] host_bus;
  } host_pins_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } port_state_e;
endpackage : host_port_pkg

// [logic/host_register_port.sv]
// Parallel eight-bit host port into the device register space.
`timescale 1ns/1ns
`include "host_port_params.svh"
module host_register_port
  import host_port_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  // Strap: 0 strobe plus direction, 1 separate strobes
  input  wire logic              sep_strobes_in,
  // Host pins
  input  wire host_pins_s        host_pins_in,
  output logic [7:0]             host_bus_out,
  output logic                   host_bus_oe_out,
  output logic                   wait_n_out,
  // Register file side
  input  wire logic [7:0]        reg_rdata_in,
  output logic [ADDR_W-1:0]      reg_addr_out,
  output logic [7:0]             reg_wdata_out,
  output logic                   reg_wr_out,
  output logic                   reg_rd_out,
  output logic                   mux_mode_out
);

  // ========================================================================
  // Synchroniser and state
  host_pins_s          sync1_ff;
  host_pins_s          sync2_ff;
  logic                ale_prev_ff;
  logic                strap_done_ff;
  logic                sep_ff;
  port_state_e         state_ff;
  port_state_e         nxt_state;
  logic [ADDR_W-1:0]   ptr_ff;
  logic [7:0]          wr_data_ff;
  logic                wr_a0_ff;
  logic [7:0]          ind_buf_ff;
  logic [2:0]          gap_ff;
  logic [2:0]          wait_cnt_ff;

  // Upper range reads go through the indirect buffer.
  function automatic logic is_target(input logic [ADDR_W-1:0] a);
    is_target = (a >= ADDR_W'(`TARGET_BASE_ADDR));
  endfunction : is_target

  // Least spacing in clocks for a data access to address a.
  function automatic logic [2:0] min_gap(input logic [ADDR_W-1:0] a);
    min_gap = a[`UPPER_HALF_BIT] ? 3'(`CYC_HI_CYCLES) : 3'(`CYC_LO_CYCLES);
  endfunction : min_gap

  // ========================================================================
  // Access decode on synchronised pins
  wire logic sel_n     = sync2_ff.cs_n;
  wire logic rd_act    = sep_ff ?
         (~sel_n & ~sync2_ff.read_strobe_pin_n & sync2_ff.write_strobe_pin_n) :
         (~sel_n & ~sync2_ff.read_strobe_pin_n & sync2_ff.write_strobe_pin_n); // RULE10
  wire logic wr_act    = sep_ff ?
         (~sel_n & ~sync2_ff.write_strobe_pin_n) :
         (~sel_n & ~sync2_ff.read_strobe_pin_n & ~sync2_ff.write_strobe_pin_n);
  wire logic ale_rise  = sync2_ff.ale & ~ale_prev_ff;
  wire logic addr_ph   = ~mux_mode_out & sync2_ff.addr_select; // RULE1 RULE4
  wire logic rd_start  = (state_ff == ST_IDLE) & rd_act;
  wire logic wr_start  = (state_ff == ST_IDLE) & ~rd_act & wr_act;
  wire logic wr_end    = (state_ff == ST_WRITE) & ~wr_act; // RULE12
  wire logic data_start = (rd_start | wr_start) & ~addr_ph;
  wire logic tgt_read  = rd_start & ~addr_ph & is_target(ptr_ff);
  wire logic [7:0] rd_sel =
         addr_ph                                  ? 8'(ptr_ff) :   // RULE9
         (ptr_ff == ADDR_W'(`INDIRECT_DATA_ADDR)) ? ind_buf_ff :   // RULE7
         is_target(ptr_ff)                        ? `JUNK_READ_VALUE : // RULE6
                                                    reg_rdata_in;  // RULE8
  wire logic [2:0] need = min_gap(ptr_ff);

  // Next access state.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  begin
        if (rd_act)      nxt_state = ST_READ;
        else if (wr_act) nxt_state = ST_WRITE;
      end
      ST_READ:  begin
        if (!rd_act)     nxt_state = ST_IDLE;
      end
      ST_WRITE: begin
        if (!wr_act)     nxt_state = ST_IDLE;
      end
      default:           nxt_state = ST_IDLE;
    endcase
  end

  // Two flops per pin; only the second stage is looked at.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_ff    <= '1;
      sync2_ff    <= '1;
      ale_prev_ff <= 1'b1;
    end else begin
      sync1_ff    <= host_pins_in;  // RULE19
      sync2_ff    <= sync1_ff;
      ale_prev_ff <= sync2_ff.ale;
    end
  end

  // Strap caught once after reset release, so it never feeds the reset.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_done_ff <= 1'b0;
      sep_ff        <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      sep_ff        <= sep_strobes_in;
    end
  end

  // Latched-address mode is sticky; the reset-idle preset of ale_prev_ff
  // means a latch strobe held through reset does not count as a rise.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mux_mode_out <= 1'b0;
    end else if (ale_rise) begin
      mux_mode_out <= 1'b1;  // RULE17 RULE18
    end
  end

  // Access state and write capture; data follows the strobes' pipeline.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff   <= ST_IDLE;
      wr_data_ff <= 8'h00;
      wr_a0_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (wr_act && state_ff != ST_READ) begin
        wr_data_ff <= sync2_ff.host_bus;
        wr_a0_ff   <= addr_ph;
      end
    end
  end

  // Pointer: latch strobe, or an address write in direct-address modes.
  // The latch strobe loads only from its first synchronised rise on, so the
  // all-ones synchroniser preset seen just after reset cannot move the
  // pointer away from its reset value.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_ff <= ADDR_W'(`POINTER_RESET);
    end else if (sync2_ff.ale && (mux_mode_out || ale_rise)) begin
      ptr_ff <= ADDR_W'(sync2_ff.host_bus);  // RULE5
    end else if (wr_end && wr_a0_ff) begin
      ptr_ff <= ADDR_W'(wr_data_ff);  // RULE2
    end
  end

  // Register strobes; the pointer is never cleared by a data access.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
      reg_wdata_out <= 8'h00;
      reg_addr_out  <= ADDR_W'(`POINTER_RESET);
    end else begin
      reg_wr_out   <= wr_end & ~wr_a0_ff;  // RULE3
      reg_rd_out   <= rd_start & ~addr_ph;
      reg_addr_out <= ptr_ff;
      if (wr_end) begin
        reg_wdata_out <= wr_data_ff;
      end
    end
  end

  // Indirect buffer takes the target value at the junk read.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ind_buf_ff <= 8'h00;
    end else if (tgt_read) begin
      ind_buf_ff <= reg_rdata_in;  // RULE6
    end
  end

  // Bus drive only while a read is seen; released when it ends.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_bus_out    <= 8'h00;
      host_bus_oe_out <= 1'b0;
    end else begin
      host_bus_oe_out <= rd_act & (state_ff != ST_WRITE);  // RULE11
      if (rd_start) begin
        host_bus_out <= rd_sel;
      end
    end
  end

  // Spacing guard. Wait is late by the synchroniser depth; that is the price
  // of sampling asynchronous strobes, and a host meeting spacing ignores it.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_ff      <= `GAP_MAX;
      wait_cnt_ff <= 3'h0;
      wait_n_out  <= 1'b1;
    end else begin
      if (data_start) begin
        gap_ff <= 3'h1;
      end else if (gap_ff != `GAP_MAX) begin
        gap_ff <= gap_ff + 3'h1;
      end
      if (data_start && gap_ff < need) begin
        wait_cnt_ff <= need - gap_ff;  // RULE14
        wait_n_out  <= 1'b0;
      end else if (wait_cnt_ff > 3'h1) begin
        wait_cnt_ff <= wait_cnt_ff - 3'h1;
      end else begin
        wait_cnt_ff <= 3'h0;
        wait_n_out  <= 1'b1;
      end
    end
  end

endmodule : host_register_port

// [verif/host_port_sva.sv]
// Assertions on the pins of the parallel host register port.
`timescale 1ns/1ns
module host_port_sva
  import host_port_pkg::*;
(
  // Watched ports
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic       sep_strobes_in,
  input wire host_pins_s host_pins_in,
  input wire logic       host_bus_oe_out,
  input wire logic       wait_n_out,
  input wire logic       reg_wr_out,
  input wire logic       reg_rd_out,
  input wire logic       mux_mode_out
);
  // ==========================================================================
  // Decoded pin states, kept here so a slip in the design decode shows.
  wire rd_pin = !host_pins_in.cs_n && !host_pins_in.read_strobe_pin_n
    && host_pins_in.write_strobe_pin_n;
  wire wr_pin = !host_pins_in.cs_n && !host_pins_in.write_strobe_pin_n
    && (sep_strobes_in || !host_pins_in.read_strobe_pin_n);
  wire acc_pin = rd_pin || wr_pin;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================================
  // Strobes pass a two-stage synchroniser, so causes sit a few edges back.
  a_oe_after_read: assert property ($rose(host_bus_oe_out) |->
    $past(rd_pin, 2) || $past(rd_pin, 3)) else $error("bus driven unasked");
  a_oe_release: assert property ((!rd_pin)[*5] |->
    !host_bus_oe_out) else $error("bus not released");
  a_rd_one_cycle: assert property (reg_rd_out |=>
    !reg_rd_out) else $error("read pulse too long");
  a_wr_commit: assert property (($past(wr_pin) && !wr_pin
    && !$past(host_pins_in.addr_select)) |-> ##[2:6] reg_wr_out)
    else $error("write not committed");
  a_mux_sticky: assert property (mux_mode_out |=>
    mux_mode_out) else $error("latched mode lost");
  a_mux_from_ale: assert property ($rose(mux_mode_out) |->
    $past(host_pins_in.ale, 2) || $past(host_pins_in.ale, 3))
    else $error("latched mode without strobe");
  a_wait_bounded: assert property (!wait_n_out ##1 !wait_n_out
    ##1 !wait_n_out |=> wait_n_out) else $error("wait held too long");
  a_wait_cause: assert property ($fell(wait_n_out) |->
    $past(acc_pin, 2) || $past(acc_pin, 3) || $past(acc_pin, 4))
    else $error("wait without access");
endmodule : host_port_sva

bind host_register_port host_port_sva u_sva (.clk_sys_in, .rst_n_in,
  .sep_strobes_in, .host_pins_in, .host_bus_oe_out, .wait_n_out,
  .reg_wr_out, .reg_rd_out, .mux_mode_out);

// [verif/reg_space_model.sv]
// Register space that stands behind the host port.
`timescale 1ns/1ns
module reg_space_model (
  // Clock and register side
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  output logic      [7:0] rdata_out
);
  // ==========================================================================
  // Plain storage, zero at start so unwritten places read defined.
  logic [7:0] mem_ff [256];
  initial foreach (mem_ff[i]) mem_ff[i] = 8'h00;
  assign rdata_out = mem_ff[addr_in];
  always @(posedge clk_sys_in) if (wr_in) mem_ff[addr_in] <= wdata_in;
endmodule : reg_space_model

// [verif/host_register_port_tb.sv]
// Self-checking bench for the parallel host register port.
`timescale 1ns/1ns
module host_register_port_tb;
  import host_port_pkg::*;
  // ==========================================================================
  // Pins, wire resolution and bookkeeping.
  logic       clk_sys_in = 1'b0;
  logic       rst_n_in, sep, cs_n, rs_n, ws_n, ale, asel, drv_en, saw_wait;
  logic       oe, wait_n, wr, rd, mux;
  logic [7:0] drv, bus, q, a, d, la, ld, host_bus_out, rdat, radr, wdat;
  int         n_errors, compares, cyc;
  integer     seed;
  host_pins_s pins;
  // A released bus shows the inverse, so stale data cannot pass.
  assign bus  = oe ? host_bus_out : (drv_en ? drv : ~drv);
  assign pins = {cs_n, rs_n, ws_n, ale, asel, bus};
  always #50 clk_sys_in = ~clk_sys_in;
  host_register_port dut (.clk_sys_in, .rst_n_in, .sep_strobes_in(sep),
    .host_pins_in(pins), .host_bus_out, .host_bus_oe_out(oe),
    .wait_n_out(wait_n), .reg_rdata_in(rdat), .reg_addr_out(radr),
    .reg_wdata_out(wdat), .reg_wr_out(wr), .reg_rd_out(rd),
    .mux_mode_out(mux));
  reg_space_model regs (.clk_sys_in, .addr_in(radr), .wdata_in(wdat),
    .wr_in(wr), .rdata_out(rdat));
  // Cycle ceiling and a note of any wait seen.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (rst_n_in && wait_n === 1'b0) saw_wait <= 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Checking, expectation and closing.
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    compares++;
    if (seen !== expv) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, expv);
    end
  endtask : check
  // Upper targets answer junk first; the real value waits in the buffer.
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, v);
    return (ad >= 8'hc0) ? 8'h00 : v;
  endfunction : exp_rd
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // One host access; strobe low for len+1 clocks, data taken before release.
  task automatic acc(input logic w, s, input logic [7:0] v, input int len, gap);
    @(posedge clk_sys_in);
    cs_n <= 1'b0;
    asel <= s;
    drv <= v;
    drv_en <= w;
    rs_n <= w & sep;
    ws_n <= !w;
    repeat (len) @(posedge clk_sys_in);
    @(negedge clk_sys_in) q = host_bus_out;
    @(posedge clk_sys_in);
    cs_n <= 1'b1;
    rs_n <= 1'b1;
    ws_n <= 1'b1;
    repeat (gap) @(posedge clk_sys_in);
  endtask : acc
  // ==========================================================================
  // Main sequence, once per strap setting, so both strobe styles are seen;
  // the latch strobe is high through each reset, the second one mid-run.
  initial begin
    seed = 32'hd165e072;
    {rst_n_in, asel, drv, saw_wait, cyc, n_errors, compares} = '0;
    {cs_n, rs_n, ws_n, ale, drv_en} = 5'h1f;
    sep = 1'($random(seed));
    for (int p = 0; p < 2; p++) begin
      rst_n_in <= 1'b0;
      ale <= 1'b1;
      saw_wait <= 1'b0;
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      ale <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      check(mux, 1'b0);
      acc(1'b0, 1'b1, 8'h00, 4, 3);
      check(q, 8'h00);
      for (int i = 0; i < 10; i++) begin
        d = 8'($random(seed));
        a = 8'($random(seed));
        a = i[0] ? (a & 8'h7f) : (a | 8'hc0);
        acc(1'b1, 1'b1, a, 4, 3);
        acc(1'b0, 1'b1, 8'h00, 4, 3);
        check(q, a);
        acc(1'b1, 1'b0, d, 4, 3);
        acc(1'b0, 1'b0, 8'h00, 4, 3);
        check(q, exp_rd(a, d));
        if (a[7]) acc(1'b1, 1'b1, 8'h88, 4, 3);
        else {la, ld} = {a, d};
        acc(1'b0, 1'b0, 8'h00, 4, 3);
        check(q, d);
      end
      // A handler saves the pointer, goes elsewhere, then restores it.
      acc(1'b0, 1'b1, 8'h00, 4, 3);
      a = q;
      check(a, la);
      acc(1'b1, 1'b1, 8'h88, 4, 3);
      acc(1'b0, 1'b0, 8'h00, 4, 3);
      acc(1'b1, 1'b1, a, 4, 3);
      acc(1'b0, 1'b0, 8'h00, 4, 3);
      check(q, ld);
      $display("test address and data done");
      check(saw_wait, 1'b0);
      acc(1'b1, 1'b1, 8'hc0, 4, 3);
      repeat (3) acc(1'b0, 1'b0, 8'h00, 0, 1);
      repeat (6) @(posedge clk_sys_in);
      check(saw_wait, 1'b1);
      $display("test wait done");
      drv <= la;
      drv_en <= 1'b1;
      ale <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      ale <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      check(mux, 1'b1);
      acc(1'b0, 1'b1, 8'h00, 4, 3);
      check(q, ld);
      d = 8'($random(seed));
      acc(1'b1, 1'b0, d, 4, 3);
      acc(1'b0, 1'b0, 8'h00, 4, 3);
      check(q, d);
      $display("test latched mode done");
      sep <= ~sep;
    end
    give_verdict();
  end
endmodule : host_register_port_tb
